// *** inc/acl_regs.vh ***
`ifndef ACL_REGS_VH
`define ACL_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACL_OFS_ARM 8'h00
`define ACL_OFS_WINLO 8'h04
`define ACL_OFS_WINHI 8'h08
`define ACL_OFS_CANCEL 8'h0C
`define ACL_OFS_SRCSEL 8'h10
`define ACL_OFS_LOGIC 8'h14
`define ACL_OFS_AXMODE 8'h18
`define ACL_OFS_PROBING 8'h1C
`define ACL_OFS_STATUS 8'h20
`define ACL_OFS_ERROR 8'h24
`define ACL_OFS_CAP 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACL_ARM_AXIS_LO 0
`define ACL_ARM_PROBE 4
`define ACL_ARM_KIND_LO 8
`define ACL_SEL_FIRST_LO 0
`define ACL_SEL_SECOND_LO 8
`define ACL_SEL_LOGIC_BIT 3
`define ACL_CANCEL_CHAN 8
`define ACL_AXMODE_ROT_LO 8
`define ACL_ST_DONE_LO 8
`define ACL_ST_SRC_LO 16
`define ACL_ERR_SPINDLE 0
`define ACL_ERR_CONFLICT 1

// ----------------------------------------
// Window kinds and reset values
// ----------------------------------------
`define ACL_WIN_NONE 2'h0
`define ACL_WIN_EXCL 2'h1
`define ACL_WIN_INCL 2'h2
`define ACL_RST_SRCSEL 32'h00000100
`define ACL_RST_ZERO 32'h00000000

`endif

// *** core/acl_win_check.v ***
`timescale 1ns/1ps
`default_nettype none
`include "acl_regs.vh"
module acl_win_check (
   input wire [31:0] pos,
   input wire [31:0] lo,
   input wire [31:0] hi,
   input wire [1:0] kind,
   output reg ok
);
   reg in_win;

   // ----------------------------------------
   // Signed window test, bounds inclusive
   // ----------------------------------------
   always @* begin
      in_win = ($signed(pos) >= $signed(lo)) && ($signed(pos) <= $signed(hi));
      case (kind)
         `ACL_WIN_EXCL: ok = ~in_win;
         `ACL_WIN_INCL: ok = in_win;
         default: ok = 1'b1;
      endcase
   end
endmodule
`default_nettype wire

// *** core/acl_top.v ***
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "acl_regs.vh"
module acl_top (
   input wire ref_clk,
   input wire rst_b,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [7:0] phys_in,
   input wire [127:0] axis_position,
   output wire [3:0] axis_capture_armed_first,
   output wire [3:0] axis_capture_armed_second,
   output wire [3:0] axis_capture_done_first,
   output wire [3:0] axis_capture_done_second,
   output reg source_armed_first,
   output reg source_armed_second
);
   // ----------------------------------------
   // Bus slave state
   // ----------------------------------------
   // Staged bounds and configuration words
   reg [31:0] winlo_r;
   reg [31:0] winhi_r;
   reg [31:0] srcsel_r;
   reg [3:0] logic_in_r;
   reg [3:0] spindle_r;
   reg [3:0] rotary_r;
   reg [1:0] probing_cycle_function;

   // Sticky errors and source history
   reg [1:0] err_r;
   reg [1:0] src_prev_r;

   // Combinational helpers
   reg [31:0] rd_nxt;
   reg [1:0] src;
   reg [3:0] sel;

   // Bus decode
   wire take;
   wire wr_take;

   // Slot results gathered per probe
   wire [7:0] armed_w;
   wire [7:0] done_w;
   wire [7:0] hit_w;
   wire [255:0] cap_w;
   wire [1:0] rise;
   wire [1:0] any_hit;

   // Arm and cancel command fields
   wire [1:0] arm_axis;
   wire arm_probe;
   wire [1:0] arm_kind;
   wire arm_go;
   wire arm_spindle_bad;
   wire arm_conflict;
   wire arm_ok;
   wire [3:0] cancel_req;
   wire chan_reset;
   wire [1:0] probe_busy;
   integer k;

   // Byte-enable merge for configuration words
   function [31:0] acl_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer b;
      begin
         acl_merge = old;
         // Lanes left low keep their old byte
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               acl_merge[b*8 +: 8] = wd[b*8 +: 8];
            end
         end
      end
   endfunction

   // Request taken only on the edge where waitrequest is low
   // Waitrequest is low for one cycle only, so a held request is taken again every second cycle
   assign take = (avs_read | avs_write) & ~avs_waitrequest;
   assign wr_take = take & avs_write;

   // ----------------------------------------
   // Arm and cancel commands
   // ----------------------------------------
   // A refused arm changes no slot; only the error bits record it
   assign arm_go = wr_take && (avs_address == `ACL_OFS_ARM);
   assign arm_axis = avs_writedata[`ACL_ARM_AXIS_LO +: 2];
   assign arm_probe = avs_writedata[`ACL_ARM_PROBE];
   assign arm_kind = avs_writedata[`ACL_ARM_KIND_LO +: 2];
   assign arm_spindle_bad = spindle_r[arm_axis] & ~rotary_r[arm_axis];
   assign arm_conflict = probing_cycle_function[arm_probe];
   assign arm_ok = arm_go & ~arm_spindle_bad & ~arm_conflict;
   // Per-axis cancel bits and the channel reset share one word
   assign cancel_req = (wr_take && (avs_address == `ACL_OFS_CANCEL)) ? avs_writedata[3:0] : 4'h0;
   assign chan_reset = wr_take && (avs_address == `ACL_OFS_CANCEL) && avs_writedata[`ACL_CANCEL_CHAN];
   // A probe counts as busy while any of its slots is armed
   assign probe_busy = {|armed_w[7:4], |armed_w[3:0]};

   // ----------------------------------------
   // Event sources
   // ----------------------------------------
   // Each select picks a physical pin or a software logic bit
   // Changing a select while latches are armed can look like an edge
   always @* begin
      for (k = 0; k < 2; k = k + 1) begin
         sel = srcsel_r[k*8 +: 4];
         if (sel[`ACL_SEL_LOGIC_BIT]) begin
            src[k] = logic_in_r[sel[1:0]];
         end else begin
            src[k] = phys_in[sel[2:0]];
         end
      end
   end

   // A rising edge of the level fires armed latches; a level already high fires a latch at arming
   // Previous level resets low like idle pins, so reset fakes no edge
   assign rise = src & ~src_prev_r;
   assign any_hit = {|hit_w[7:4], |hit_w[3:0]};

   // ----------------------------------------
   // One slot per probe and axis
   // ----------------------------------------
   // Slot index is probe times four plus axis
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_slot
         localparam PRB = i / 4;
         localparam AX = i % 4;
         reg armed_r;
         reg done_r;
         reg [1:0] kind_r;
         reg [31:0] lo_r;
         reg [31:0] hi_r;
         reg [31:0] cap_r;

         // Slot decode and window inputs
         wire arm_here;
         wire [1:0] kind_use;
         wire [31:0] lo_use;
         wire [31:0] hi_use;
         wire [31:0] pos;
         wire win_ok;
         wire hit;
         wire kill;

         // Live position of this slot's axis
         assign pos = axis_position[AX*32 +: 32];
         assign arm_here = arm_ok && (arm_axis == AX) && (arm_probe == PRB);
         // A fresh arm uses its own window in the very same cycle
         assign kind_use = arm_here ? arm_kind : kind_r;
         assign lo_use = arm_here ? winlo_r : lo_r;
         assign hi_use = arm_here ? winhi_r : hi_r;

         // Window test on the live position
         acl_win_check u_win (
            .pos(pos),
            .lo(lo_use),
            .hi(hi_use),
            .kind(kind_use),
            .ok(win_ok)
         );

         // Edge on any armed slot, or level already present at arming
         assign hit = win_ok & (((armed_r | arm_here) & rise[PRB]) | (arm_here & src[PRB]));
         // Any accepted event on the probe ends all its slots
         assign kill = any_hit[PRB] | cancel_req[AX] | chan_reset;

         // Slot results onto the shared vectors
         assign hit_w[i] = hit;
         assign armed_w[i] = armed_r;
         assign done_w[i] = done_r;
         assign cap_w[i*32 +: 32] = cap_r;

         // Slot flags; a done set wins over the arming clear
         always @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               armed_r <= 1'b0;
               done_r <= 1'b0;
               kind_r <= `ACL_WIN_NONE;
               lo_r <= `ACL_RST_ZERO;
               hi_r <= `ACL_RST_ZERO;
               cap_r <= `ACL_RST_ZERO;
            end else begin
               armed_r <= (armed_r | arm_here) & ~kill;
               done_r <= (done_r & ~arm_here) | hit;
               // Window and kind frozen at arming; later bound writes only stage
               if (arm_here) begin
                  kind_r <= arm_kind;
                  lo_r <= winlo_r;
                  hi_r <= winhi_r;
               end
               // Capture holds until the next accepted event on this slot
               if (hit) begin
                  cap_r <= pos;
               end
            end
         end
      end
   endgenerate

   // Flag vectors split per probe onto the output pins
   assign axis_capture_armed_first = armed_w[3:0];
   assign axis_capture_armed_second = armed_w[7:4];
   assign axis_capture_done_first = done_w[3:0];
   assign axis_capture_done_second = done_w[7:4];

   // ----------------------------------------
   // Per-probe flags and errors
   // ----------------------------------------
   // Source armed follows the slot flags one cycle later, as a flop
   // Trade-off: one cycle of lag buys a registered output
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         source_armed_first <= 1'b0;
         source_armed_second <= 1'b0;
         src_prev_r <= 2'b00;
      end else begin
         source_armed_first <= |armed_w[3:0];
         source_armed_second <= |armed_w[7:4];
         // Level history for the edge detector
         src_prev_r <= src;
      end
   end

   // Sticky errors, write one to clear; a new error wins the clear
   // Conflict also holds while a probing cycle overlaps an armed probe
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_r <= 2'b00;
      end else begin
         if (wr_take && (avs_address == `ACL_OFS_ERROR)) begin
            err_r <= (err_r & ~avs_writedata[1:0]) |
               {arm_go & arm_conflict, arm_go & arm_spindle_bad} |
               {|(probing_cycle_function & probe_busy), 1'b0};
         end else begin
            err_r[`ACL_ERR_SPINDLE] <= err_r[`ACL_ERR_SPINDLE] | (arm_go & arm_spindle_bad);
            err_r[`ACL_ERR_CONFLICT] <= err_r[`ACL_ERR_CONFLICT] | (arm_go & arm_conflict) |
               (|(probing_cycle_function & probe_busy));
         end
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Writes land on the edge where waitrequest is sampled low
   // Status and capture words are read-only; the error word is write-one-to-clear
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         winlo_r <= `ACL_RST_ZERO;
         winhi_r <= `ACL_RST_ZERO;
         srcsel_r <= `ACL_RST_SRCSEL;
         logic_in_r <= 4'h0;
         spindle_r <= 4'h0;
         rotary_r <= 4'h0;
         probing_cycle_function <= 2'b00;
      end else if (wr_take) begin
         case (avs_address)
            `ACL_OFS_WINLO: winlo_r <= acl_merge(winlo_r, avs_writedata, avs_byteenable);
            `ACL_OFS_WINHI: winhi_r <= acl_merge(winhi_r, avs_writedata, avs_byteenable);
            `ACL_OFS_SRCSEL: srcsel_r <= acl_merge(srcsel_r, avs_writedata, avs_byteenable);
            `ACL_OFS_LOGIC: begin
               // Software logic inputs act as event sources once selected
               if (avs_byteenable[0]) begin
                  logic_in_r <= avs_writedata[3:0];
               end
            end
            `ACL_OFS_AXMODE: begin
               // Spindle and rotary bits together decide if arming is allowed
               if (avs_byteenable[0]) begin
                  spindle_r <= avs_writedata[3:0];
               end
               if (avs_byteenable[1]) begin
                  rotary_r <= avs_writedata[`ACL_AXMODE_ROT_LO +: 4];
               end
            end
            `ACL_OFS_PROBING: begin
               if (avs_byteenable[0]) begin
                  probing_cycle_function <= avs_writedata[1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Unmapped addresses read as zero
   always @* begin
      rd_nxt = 32'h00000000;
      case (avs_address)
         `ACL_OFS_WINLO: rd_nxt = winlo_r;
         `ACL_OFS_WINHI: rd_nxt = winhi_r;
         `ACL_OFS_SRCSEL: rd_nxt = srcsel_r;
         `ACL_OFS_LOGIC: rd_nxt[3:0] = logic_in_r;
         `ACL_OFS_AXMODE: rd_nxt = {20'h00000, rotary_r, 4'h0, spindle_r};
         `ACL_OFS_PROBING: rd_nxt[1:0] = probing_cycle_function;
         `ACL_OFS_STATUS: begin
            // Armed, done and per-probe flags in one word
            rd_nxt[7:0] = armed_w;
            rd_nxt[`ACL_ST_DONE_LO +: 8] = done_w;
            rd_nxt[`ACL_ST_SRC_LO +: 2] = {source_armed_second, source_armed_first};
         end
         `ACL_OFS_ERROR: rd_nxt[1:0] = err_r;
         default: begin
            // One capture word per probe and axis from the capture base
            if (avs_address[7:5] == 3'h2) begin
               rd_nxt = cap_w[avs_address[4:2]*32 +: 32];
            end
         end
      endcase
   end

   // ----------------------------------------
   // Waitrequest handshake
   // ----------------------------------------
   // One wait state: low for one cycle, then back high
   // Read data load in the wait cycle, so they stand while waitrequest is low
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= `ACL_RST_ZERO;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         // Writes return zero rather than stale read data
         if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_readdata <= avs_read ? rd_nxt : 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/acl_probe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acl_probe_model #(parameter int LAG = 3) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] level,
   output logic [7:0] phys_in
);
   logic [8*LAG-1:0] dly_r;
   // ----------------------------------------
   // Input wiring
   // ----------------------------------------
   // Slow switch: a level reaches the pins LAG cycles late, like a debounced probe
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dly_r <= '0;
      end else begin
         dly_r <= {dly_r[8*LAG-9:0], level};
      end
   end
   assign phys_in = dly_r[8*LAG-1 -: 8];
endmodule
`default_nettype wire

// *** verification/acl_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module acl_top_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [3:0] axis_capture_armed_first,
   input wire logic [3:0] axis_capture_armed_second,
   input wire logic [3:0] axis_capture_done_first,
   input wire logic [3:0] axis_capture_done_second,
   input wire logic source_armed_first,
   input wire logic source_armed_second
);
   // ----------------------------------------
   // Bus and flag relations
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Answer lasts exactly one cycle, so a held request is taken again every second cycle
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in the next cycle");
   src_first_a: assert property (source_armed_first == $past(|axis_capture_armed_first))
      else $error("first source flag disagrees with armed flags");
   src_second_a: assert property (source_armed_second == $past(|axis_capture_armed_second))
      else $error("second source flag disagrees with armed flags");
   arm_clear_a: assert property ((axis_capture_armed_first & ~$past(axis_capture_armed_first) & axis_capture_done_first) == 4'h0)
      else $error("done still set on a newly armed axis");
   arm_cause_a: assert property (|(axis_capture_armed_first & ~$past(axis_capture_armed_first)) || |(axis_capture_armed_second & ~$past(axis_capture_armed_second)) |-> $past(avs_write && !avs_waitrequest))
      else $error("armed flag rose without a write");
   cancel_cause_a: assert property (|(~axis_capture_armed_first & $past(axis_capture_armed_first)) |-> $past(avs_write && !avs_waitrequest) || |(axis_capture_done_first & ~$past(axis_capture_done_first)))
      else $error("armed flag fell without cancel or event");
   event_cancel_a: assert property (|(axis_capture_done_second & ~$past(axis_capture_done_second)) |-> axis_capture_armed_second == 4'h0)
      else $error("event left a latch armed on its probe");
   cover property (|(axis_capture_done_first & ~$past(axis_capture_done_first)));
   cover property (|(axis_capture_done_second & ~$past(axis_capture_done_second)));
   cover property ($fell(source_armed_first));
endmodule
bind acl_top acl_top_checker chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .axis_capture_armed_first(axis_capture_armed_first),
   .axis_capture_armed_second(axis_capture_armed_second), .axis_capture_done_first(axis_capture_done_first),
   .axis_capture_done_second(axis_capture_done_second), .source_armed_first(source_armed_first),
   .source_armed_second(source_armed_second));
`default_nettype wire

// *** verification/test_axis_coordinate_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acl_regs.vh"
module test_axis_coordinate_latch;
   localparam logic [127:0] POS = {32'h00003000, 32'h00002000, 32'hFFFFF000, 32'h00001000};
   logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address, phys_in, level;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [3:0] avs_byteenable, armed_first, armed_second, done_first, done_second;
   logic [127:0] axis_position;
   logic source_armed_first, source_armed_second;
   integer err_total, n_checks, cyc;
   acl_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phys_in(phys_in),
      .axis_position(axis_position), .axis_capture_armed_first(armed_first),
      .axis_capture_armed_second(armed_second), .axis_capture_done_first(done_first),
      .axis_capture_done_second(done_second), .source_armed_first(source_armed_first),
      .source_armed_second(source_armed_second));
   acl_probe_model #(.LAG(3)) model (.ref_clk(ref_clk), .rst_b(rst_b), .level(level), .phys_in(phys_in));
   // ----------------------------------------
   // Clock, timeout and verdict
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Ceiling far above the roughly 140 cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         summarize;
      end
   end
   task summarize;
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Bus tasks, entered just after a rising edge
   // ----------------------------------------
   task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One idle edge, so the next call never reassigns a strobe in this step
      @(posedge ref_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task ck(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h00000000);
      n_checks = n_checks + 1;
      if (rdv !== e) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", n, e, rdv);
      end
   endtask
   // Output pins in the status word's layout
   task ckp(input string n, input logic [17:0] e);
      logic [17:0] s;
      s = {source_armed_second, source_armed_first, done_second, done_first, armed_second, armed_first};
      n_checks = n_checks + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      level = 8'h00;
      axis_position = POS;
      err_total = 0;
      n_checks = 0;
      cyc = 0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      ck("srcsel", `ACL_OFS_SRCSEL, 32'h00000100);
      // Axis1 window misses its position: cancelled but never done
      wr(`ACL_OFS_WINLO, 32'h00000000);
      wr(`ACL_OFS_WINHI, 32'h00000010);
      wr(`ACL_OFS_ARM, 32'h00000000);
      wr(`ACL_OFS_ARM, 32'h00000201);
      wr(`ACL_OFS_ARM, 32'h00000012);
      ck("status", `ACL_OFS_STATUS, 32'h00030043);
      ckp("pins", 18'h30043);
      level <= 8'h01;
      while (phys_in[0] !== 1'b1) @(posedge ref_clk);
      // Per-probe flag drops one edge after the slots
      @(posedge ref_clk);
      ck("status", `ACL_OFS_STATUS, 32'h00020140);
      ckp("pins", 18'h20140);
      ck("capture", `ACL_OFS_CAP, POS[31:0]);
      // Position on the lower bound counts as inside, so exclusive refuses it
      wr(`ACL_OFS_WINLO, 32'h00002000);
      wr(`ACL_OFS_WINHI, 32'h00002FFF);
      wr(`ACL_OFS_ARM, 32'h00000112);
      level <= 8'h02;
      while (phys_in[1] !== 1'b1) @(posedge ref_clk);
      ck("status", `ACL_OFS_STATUS, 32'h00020140);
      wr(`ACL_OFS_WINHI, 32'h00002000);
      wr(`ACL_OFS_ARM, 32'h00000212);
      wr(`ACL_OFS_ARM, 32'h00000000);
      ck("status", `ACL_OFS_STATUS, 32'h00014001);
      ckp("pins", 18'h14001);
      ck("capture", `ACL_OFS_CAP + 8'h18, POS[95:64]);
      // Spindle refusal, then conflict with a probing cycle
      wr(`ACL_OFS_AXMODE, 32'h00000002);
      wr(`ACL_OFS_ARM, 32'h00000001);
      ck("error", `ACL_OFS_ERROR, 32'h00000001);
      wr(`ACL_OFS_AXMODE, 32'h00000202);
      wr(`ACL_OFS_ARM, 32'h00000001);
      ck("status", `ACL_OFS_STATUS, 32'h00014003);
      wr(`ACL_OFS_ERROR, 32'h00000003);
      wr(`ACL_OFS_PROBING, 32'h00000002);
      wr(`ACL_OFS_ARM, 32'h00000013);
      ck("error", `ACL_OFS_ERROR, 32'h00000002);
      wr(`ACL_OFS_CANCEL, 32'h00000001);
      ck("status", `ACL_OFS_STATUS, 32'h00014002);
      wr(`ACL_OFS_CANCEL, 32'h00000100);
      ck("status", `ACL_OFS_STATUS, 32'h00004000);
      ckp("pins", 18'h04000);
      ck("unmapped", 8'h30, 32'h00000000);
      // Second source moved to a software logic input
      wr(`ACL_OFS_PROBING, 32'h00000000);
      wr(`ACL_OFS_SRCSEL, 32'h00000800);
      wr(`ACL_OFS_ARM, 32'h00000013);
      wr(`ACL_OFS_LOGIC, 32'h00000001);
      // Event lands one edge after the write; flag follows one more
      @(posedge ref_clk);
      ck("status", `ACL_OFS_STATUS, 32'h0000C000);
      ckp("pins", 18'h0C000);
      ck("capture", `ACL_OFS_CAP + 8'h1C, POS[127:96]);
      summarize;
   end
endmodule
`default_nettype wire
